/* verilog/mcr_pkg.sv */
// Shared constants of the misc control register bank: register indexes,
// field positions, reset values and timing counts.
// Assumes a 100 MHz system clock and a 32-bit classic Wishbone host.
`default_nettype none
package mcr_pkg;
  // Clock and register indexes (byte address is four times the index)
  localparam int MCR_CLK_MHZ = 100;
  localparam logic [9:0] MCR_IDX_BUS_SPEED = 10'h210;
  localparam logic [9:0] MCR_IDX_EE_CTRL = 10'h212;
  localparam logic [9:0] MCR_IDX_SELFTEST = 10'h214;
  localparam logic [9:0] MCR_IDX_SOFT_RST = 10'h216;
  localparam logic [9:0] MCR_IDX_CAPS = 10'h218;
  localparam logic [9:0] MCR_IDX_PM_CTRL = 10'h220;
  // Field positions
  localparam int MCR_EE_SA_BIT = 4;
  localparam int MCR_EE_SI_BIT = 3;
  localparam int MCR_EE_SO_BIT = 2;
  localparam int MCR_EE_SK_BIT = 1;
  localparam int MCR_EE_CS_BIT = 0;
  localparam int MCR_TX_DONE_BIT = 12;
  localparam int MCR_TX_FAIL_BIT = 11;
  localparam int MCR_RX_DONE_BIT = 4;
  localparam int MCR_RX_FAIL_BIT = 3;
  localparam int MCR_SRST_BIT = 0;
  localparam int MCR_PM_EN_BIT = 8;
  localparam int MCR_PM_STS_BIT = 15;
  localparam int MCR_CAP_WAKE_D0_BIT = 11;
  // Reset values and capability masks
  localparam logic [1:0] MCR_SPEED_RST = 2'h3;
  localparam logic [15:0] MCR_CAP_RST = 16'h4000;
  localparam logic [15:0] MCR_CAP_LOAD_MASK = 16'h362f;
  localparam logic [2:0] MCR_DIV_125 = 3'h1;
  localparam logic [2:0] MCR_DIV_62P5 = 3'h2;
  localparam logic [2:0] MCR_DIV_41P66 = 3'h3;
  localparam logic [2:0] MCR_DIV_25 = 3'h5;
  // EEPROM read of the configuration word
  localparam int MCR_EE_SK_HALF_NS = 500;
  localparam int MCR_EE_SK_HALF_CYC =
    (MCR_EE_SK_HALF_NS * MCR_CLK_MHZ + 999) / 1000;
  localparam logic [8:0] MCR_EE_READ_CMD = 9'h186;
  localparam logic [4:0] MCR_EE_CMD_BITS = 5'h09;
  localparam logic [4:0] MCR_EE_LAST_BIT = 5'h18;
endpackage
`default_nettype wire

/* verilog/mcr_ee_loader.sv */
// Serial EEPROM reader that fetches the configuration word once.
// Assumes a three-wire serial EEPROM and a synchronised data input.
`default_nettype none
module mcr_ee_loader
  import mcr_pkg::*;
#(
  parameter int HALF_CYC = MCR_EE_SK_HALF_CYC // 4 or more: pin and sync lag
) (
  // Clock, reset, enable
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // Control
  input wire logic i_start,
  output logic o_busy,
  output logic o_done,
  output logic [15:0] o_word,
  // EEPROM pins
  input wire logic i_serial_in,
  output logic o_select,
  output logic o_clock,
  output logic o_serial_out
);
  typedef enum logic [1:0] {MCR_LD_IDLE, MCR_LD_RUN, MCR_LD_END} mcr_ld_t;
  mcr_ld_t state_r;
  logic [15:0] cnt_r;
  logic [4:0] idx_r;
  logic [8:0] cmd_r;
  logic tick;

  // End of one half period of the serial clock
  assign tick = (cnt_r == 16'(HALF_CYC - 1));
  assign o_busy = (state_r != MCR_LD_IDLE);
  assign o_done = (state_r == MCR_LD_END);

  // Sequencer: command bits out, then sixteen data bits in
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r <= MCR_LD_IDLE;
      cnt_r <= 16'h0000;
      idx_r <= 5'h00;
      cmd_r <= 9'h000;
      o_select <= 1'b0;
      o_clock <= 1'b0;
      o_serial_out <= 1'b0;
    end else if (i_ce) begin
      case (state_r)
        MCR_LD_IDLE: begin
          if (i_start) begin
            state_r <= MCR_LD_RUN;
            cnt_r <= 16'h0000;
            idx_r <= 5'h00;
            o_select <= 1'b1;
            o_serial_out <= MCR_EE_READ_CMD[8];
            cmd_r <= {MCR_EE_READ_CMD[7:0], 1'b0};
          end
        end
        MCR_LD_RUN: begin
          cnt_r <= tick ? 16'h0000 : cnt_r + 16'h0001;
          if (tick && !o_clock) begin
            o_clock <= 1'b1;
          end else if (tick) begin
            o_clock <= 1'b0;
            o_serial_out <= cmd_r[8];
            cmd_r <= {cmd_r[7:0], 1'b0};
            idx_r <= idx_r + 5'h01;
            if (idx_r == MCR_EE_LAST_BIT) begin
              state_r <= MCR_LD_END;
              o_select <= 1'b0;
            end
          end
        end
        MCR_LD_END: state_r <= MCR_LD_IDLE;
        default: state_r <= MCR_LD_IDLE;
      endcase
    end
  end

  // Data bits are taken at the end of each high phase
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_word <= 16'h0000;
    end else if (i_ce && state_r == MCR_LD_RUN && tick && o_clock &&
                 idx_r >= MCR_EE_CMD_BITS) begin
      o_word <= {o_word[14:0], i_serial_in};
    end
  end
endmodule
`default_nettype wire

/* verilog/mcr_misc_ctrl.sv */
// Misc control register bank: bus speed, EEPROM pin port, self test
// flags, soft reset, power capabilities and wake event output.
// Assumes a classic Wishbone master and memory self test logic on the
// same clock; EEPROM pins and the strap come from outside.
//
// Design decision made here: the Wishbone register port.
`default_nettype none
module mcr_misc_ctrl
  import mcr_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int EE_HALF_CYC = MCR_EE_SK_HALF_CYC
) (
  // Clock, reset, enable
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // Wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [ADDR_W-1:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // EEPROM pins and strap
  input wire logic i_eeprom_present_strap,
  input wire logic i_eeprom_serial_in,
  output logic o_eeprom_serial_out,
  output logic o_eeprom_serial_clock,
  output logic o_eeprom_select,
  // Memory self test
  input wire logic i_tx_selftest_done,
  input wire logic i_tx_selftest_fail,
  input wire logic i_rx_selftest_done,
  input wire logic i_rx_selftest_fail,
  output logic o_selftest_start,
  // Wake event
  input wire logic i_wake_request,
  output logic o_wake_event_out,
  output logic o_wake_event_oe_n,
  // Device control
  output logic [1:0] o_bus_speed_sel,
  output logic [2:0] o_bus_clk_div,
  output logic o_soft_reset,
  output logic [15:0] o_config_caps_mirror
);
  logic [1:0] rst_sync_r;
  logic rst_n;
  logic [1:0] strap_sync_r;
  logic [1:0] si_sync_r;
  logic strap_r;
  logic [1:0] boot_cnt_r;
  logic boot_go;
  logic [1:0] speed_r;
  logic ee_sa_r;
  logic ee_so_r;
  logic ee_sk_r;
  logic ee_cs_r;
  logic srst_r;
  logic tx_done_r;
  logic tx_fail_r;
  logic rx_done_r;
  logic rx_fail_r;
  logic [15:0] cap_r;
  logic [1:0] pm_state_r;
  logic pm_en_r;
  logic pm_sts_r;
  logic ack_r;
  logic req;
  logic wr_go;
  logic rd_go;
  logic [9:0] idx;
  logic [15:0] wdat;
  logic [15:0] rd_mux;
  logic ld_busy;
  logic ld_done;
  logic [15:0] ld_word;
  logic ld_cs;
  logic ld_sk;
  logic ld_so;
  logic wake_allow;

  // Reset release through two flip-flops
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // Pin inputs pass two flip-flops
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      strap_sync_r <= 2'h0;
      si_sync_r <= 2'h0;
    end else if (i_ce) begin
      strap_sync_r <= {strap_sync_r[0], i_eeprom_present_strap};
      si_sync_r <= {si_sync_r[0], i_eeprom_serial_in};
    end
  end

  // Startup: wait for the synchronisers, then catch the strap once
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      boot_cnt_r <= 2'h0;
      strap_r <= 1'b0;
    end else if (i_ce && boot_cnt_r != 2'h3) begin
      boot_cnt_r <= boot_cnt_r + 2'h1;
      if (boot_cnt_r == 2'h2) begin
        strap_r <= strap_sync_r[1];
      end
    end
  end
  assign boot_go = i_ce && (boot_cnt_r == 2'h2);

  // Self test kicked off once after hardware reset
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      o_selftest_start <= 1'b0;
    end else if (i_ce) begin
      o_selftest_start <= boot_go;
    end
  end

  // Wishbone decode; one wait state, unmapped reads give zero
  assign req = i_wb_cyc && i_wb_stb && !ack_r;
  assign wr_go = i_ce && req && i_wb_we;
  assign rd_go = i_ce && req && !i_wb_we;
  assign idx = i_wb_adr[ADDR_W-1:2];
  assign o_wb_ack = ack_r;

  // Byte lanes 0 and 1 carry the 16-bit registers
  always_comb begin
    wdat = 16'h0000;
    if (i_wb_sel[0]) begin
      wdat[7:0] = i_wb_dat[7:0];
    end
    if (i_wb_sel[1]) begin
      wdat[15:8] = i_wb_dat[15:8];
    end
  end

  // Acknowledge one cycle after the request
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
    end else if (i_ce) begin
      ack_r <= req;
    end
  end

  // Bus speed select, back to default under soft reset
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      speed_r <= MCR_SPEED_RST;
    end else if (i_ce) begin
      if (srst_r) begin
        speed_r <= MCR_SPEED_RST;
      end else if (wr_go && idx == MCR_IDX_BUS_SPEED && i_wb_sel[0]) begin
        speed_r <= wdat[1:0];
      end
    end
  end

  // Speed code to bus clock divider of the 125 MHz source
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      o_bus_clk_div <= MCR_DIV_25;
    end else if (i_ce) begin
      case (speed_r)
        2'h0: o_bus_clk_div <= MCR_DIV_125;
        2'h1: o_bus_clk_div <= MCR_DIV_62P5;
        2'h2: o_bus_clk_div <= MCR_DIV_41P66;
        default: o_bus_clk_div <= MCR_DIV_25;
      endcase
    end
  end
  assign o_bus_speed_sel = speed_r;

  // EEPROM control bits, defaulted under soft reset
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      ee_sa_r <= 1'b0;
      ee_so_r <= 1'b0;
      ee_sk_r <= 1'b0;
      ee_cs_r <= 1'b0;
    end else if (i_ce) begin
      if (srst_r) begin
        ee_sa_r <= 1'b0;
        ee_so_r <= 1'b0;
        ee_sk_r <= 1'b0;
        ee_cs_r <= 1'b0;
      end else if (wr_go && idx == MCR_IDX_EE_CTRL && i_wb_sel[0]) begin
        ee_sa_r <= wdat[MCR_EE_SA_BIT];
        ee_so_r <= wdat[MCR_EE_SO_BIT];
        ee_sk_r <= wdat[MCR_EE_SK_BIT];
        ee_cs_r <= wdat[MCR_EE_CS_BIT];
      end
    end
  end

  // Configuration word reader, started once when the strap is high
  mcr_ee_loader #(
    .HALF_CYC(EE_HALF_CYC)
  ) u_loader (
    .i_clk(i_mclk),
    .i_rst_n(rst_n),
    .i_ce(i_ce),
    .i_start(boot_go && strap_sync_r[1]),
    .o_busy(ld_busy),
    .o_done(ld_done),
    .o_word(ld_word),
    .i_serial_in(si_sync_r[1]),
    .o_select(ld_cs),
    .o_clock(ld_sk),
    .o_serial_out(ld_so)
  );

  // EEPROM pins: loader first, then software, idle low otherwise
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      o_eeprom_select <= 1'b0;
      o_eeprom_serial_clock <= 1'b0;
      o_eeprom_serial_out <= 1'b0;
    end else if (i_ce) begin
      if (ld_busy) begin
        o_eeprom_select <= ld_cs;
        o_eeprom_serial_clock <= ld_sk;
        o_eeprom_serial_out <= ld_so;
      end else if (strap_r && ee_sa_r) begin
        o_eeprom_select <= ee_cs_r;
        o_eeprom_serial_clock <= ee_sk_r;
        o_eeprom_serial_out <= ee_so_r;
      end else begin
        o_eeprom_select <= 1'b0;
        o_eeprom_serial_clock <= 1'b0;
        o_eeprom_serial_out <= 1'b0;
      end
    end
  end

  // Self test flags: sticky until the next hardware reset
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      tx_done_r <= 1'b0;
      tx_fail_r <= 1'b0;
      rx_done_r <= 1'b0;
      rx_fail_r <= 1'b0;
    end else if (i_ce) begin
      tx_done_r <= tx_done_r | i_tx_selftest_done;
      tx_fail_r <= tx_fail_r | i_tx_selftest_fail;
      rx_done_r <= rx_done_r | i_rx_selftest_done;
      rx_fail_r <= rx_fail_r | i_rx_selftest_fail;
    end
  end

  // Soft reset bit: held until software writes zero
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      srst_r <= 1'b0;
    end else if (i_ce && wr_go && idx == MCR_IDX_SOFT_RST &&
                 i_wb_sel[0]) begin
      srst_r <= wdat[MCR_SRST_BIT];
    end
  end
  assign o_soft_reset = srst_r;

  // Capabilities: fixed bits plus loaded bits, never bus-written
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      cap_r <= MCR_CAP_RST;
    end else if (i_ce && ld_done) begin
      cap_r <= (ld_word & MCR_CAP_LOAD_MASK) | MCR_CAP_RST;
    end
  end

  // Mirror into the configuration identifier upper half
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      o_config_caps_mirror <= MCR_CAP_RST;
    end else if (i_ce) begin
      o_config_caps_mirror <= cap_r;
    end
  end

  // Power control: state and wake enable, kept through soft reset
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      pm_state_r <= 2'h0;
      pm_en_r <= 1'b0;
    end else if (i_ce && wr_go && idx == MCR_IDX_PM_CTRL) begin
      if (i_wb_sel[0]) begin
        pm_state_r <= wdat[1:0];
      end
      if (i_wb_sel[1]) begin
        pm_en_r <= wdat[MCR_PM_EN_BIT];
      end
    end
  end

  // Wake status: set by a request, write one clears, set wins
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      pm_sts_r <= 1'b0;
    end else if (i_ce) begin
      if (i_wake_request) begin
        pm_sts_r <= 1'b1;
      end else if (wr_go && idx == MCR_IDX_PM_CTRL && i_wb_sel[1] &&
                   wdat[MCR_PM_STS_BIT]) begin
        pm_sts_r <= 1'b0;
      end
    end
  end

  // Capability bit of the present power state allows the wake pin
  assign wake_allow = cap_r[MCR_CAP_WAKE_D0_BIT + int'(pm_state_r)];

  // Open-drain wake output, pulled low while asserted
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      o_wake_event_oe_n <= 1'b1;
    end else if (i_ce) begin
      o_wake_event_oe_n <= !(pm_sts_r && pm_en_r && wake_allow);
    end
  end
  assign o_wake_event_out = 1'b0;

  // Read multiplexer
  always_comb begin
    rd_mux = 16'h0000;
    case (idx)
      MCR_IDX_BUS_SPEED: rd_mux[1:0] = speed_r;
      MCR_IDX_EE_CTRL: begin
        rd_mux[MCR_EE_SA_BIT] = ee_sa_r;
        rd_mux[MCR_EE_SI_BIT] = si_sync_r[1];
        rd_mux[MCR_EE_SO_BIT] = ee_so_r;
        rd_mux[MCR_EE_SK_BIT] = ee_sk_r;
        rd_mux[MCR_EE_CS_BIT] = ee_cs_r;
      end
      MCR_IDX_SELFTEST: begin
        rd_mux[MCR_TX_DONE_BIT] = tx_done_r;
        rd_mux[MCR_TX_FAIL_BIT] = tx_fail_r;
        rd_mux[MCR_RX_DONE_BIT] = rx_done_r;
        rd_mux[MCR_RX_FAIL_BIT] = rx_fail_r;
      end
      MCR_IDX_SOFT_RST: rd_mux[MCR_SRST_BIT] = srst_r;
      MCR_IDX_CAPS: rd_mux = cap_r;
      MCR_IDX_PM_CTRL: begin
        rd_mux[1:0] = pm_state_r;
        rd_mux[MCR_PM_EN_BIT] = pm_en_r;
        rd_mux[MCR_PM_STS_BIT] = pm_sts_r;
      end
      default: rd_mux = 16'h0000;
    endcase
  end

  // Read data captured with the acknowledge
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      o_wb_dat <= 32'h0000_0000;
    end else if (rd_go) begin
      o_wb_dat <= {16'h0000, rd_mux};
    end
  end
endmodule
`default_nettype wire

/* tb/mcr_eeprom_model.sv */
// Behavioural three-wire serial EEPROM holding one configuration word.
// Assumes read commands only; an unknown command returns zeros.
`default_nettype none
module mcr_eeprom_model
  import mcr_pkg::*;
#(
  parameter logic [15:0] WORD = 16'h0
) (
  // EEPROM pins
  input wire logic i_select,
  input wire logic i_clock,
  input wire logic i_data_in,
  output logic o_data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] cmd;
  logic [15:0] sh;
  int n;
  initial begin
    o_data_out = 1'h1;
    n = 0;
  end
  // Released line shows the inverse of its last level
  always @(negedge i_select) begin
    n = 0;
    o_data_out = ~o_data_out;
  end
  // Command shifts in, then data shifts out MSB first
  always @(posedge i_clock) begin
    if (i_select) begin
      if (n < 9) cmd = {cmd[7:0], i_data_in};
      if (n == 8) sh = (cmd == MCR_EE_READ_CMD) ? WORD : 16'h0;
      if (n >= 9 && n < 25) begin
        o_data_out = sh[15];
        sh = {sh[14:0], 1'h0};
      end
      n++;
    end
  end
endmodule
`default_nettype wire

/* tb/mcr_misc_ctrl_assertions.sv */
// Checker of the misc control register bank, seeing top ports only.
// Assumes the master keeps its request steady while ack is sampled.
`default_nettype none
module mcr_misc_ctrl_chk
  import mcr_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // Clock, reset and bus
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_wb_we,
  input wire logic [ADDR_W-1:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  input wire logic [31:0] o_wb_dat,
  input wire logic o_wb_ack,
  // Pins, self test and control
  input wire logic i_eeprom_present_strap,
  input wire logic i_eeprom_serial_in,
  input wire logic o_eeprom_serial_out,
  input wire logic o_eeprom_serial_clock,
  input wire logic o_eeprom_select,
  input wire logic i_tx_selftest_done,
  input wire logic i_tx_selftest_fail,
  input wire logic i_rx_selftest_done,
  input wire logic i_rx_selftest_fail,
  input wire logic [1:0] o_bus_speed_sel,
  input wire logic [2:0] o_bus_clk_div,
  input wire logic o_soft_reset,
  input wire logic [15:0] o_config_caps_mirror
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] idx;
  logic rd;
  logic wr;
  logic [2:0] pins;
  logic [3:0] si_h;
  logic [3:0] st;
  // Access decode at the acknowledge edge
  assign idx = i_wb_adr[11:2];
  assign rd = o_wb_ack && !i_wb_we;
  assign wr = o_wb_ack && i_wb_we && i_wb_sel[0];
  assign pins = {o_eeprom_serial_out, o_eeprom_serial_clock,
    o_eeprom_select};
  // History of the serial input pin
  always_ff @(posedge i_mclk) begin
    si_h <= {si_h[2:0], i_eeprom_serial_in};
  end
  // Self test events seen since hardware reset
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st <= 4'h0;
    end else begin
      st <= st | {i_tx_selftest_done, i_tx_selftest_fail,
        i_rx_selftest_done, i_rx_selftest_fail};
    end
  end
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  a_div_from_code: assert property (
    $stable(o_bus_speed_sel) |-> o_bus_clk_div ==
    (o_bus_speed_sel == 2'h0 ? 3'h1 : o_bus_speed_sel == 2'h1 ? 3'h2 :
    o_bus_speed_sel == 2'h2 ? 3'h3 : 3'h5))
    else $error("bus divide does not match speed code");
  a_speed_at_reset: assert property (
    $rose(i_rst_n) |-> o_bus_speed_sel == 2'h3 && o_bus_clk_div == 3'h5)
    else $error("speed code not slowest after reset");
  a_pins_follow_bits: assert property (
    wr && idx == MCR_IDX_EE_CTRL && i_wb_dat[4] && !o_soft_reset &&
    i_eeprom_present_strap |=> pins == $past(i_wb_dat[2:0]))
    else $error("EEPROM pins do not follow written bits");
  a_pins_off_unowned: assert property (
    wr && idx == MCR_IDX_EE_CTRL && !i_wb_dat[4] |=> pins == 3'h0)
    else $error("EEPROM pins driven without soft access");
  a_no_strap_quiet: assert property (
    !i_eeprom_present_strap |-> pins == 3'h0)
    else $error("EEPROM pins active with strap low");
  a_serial_in_live: assert property (
    rd && idx == MCR_IDX_EE_CTRL && si_h inside {4'h0, 4'hf} |->
    o_wb_dat[3] == si_h[0])
    else $error("serial input bit does not show pin level");
  a_selftest_flags: assert property (
    rd && idx == MCR_IDX_SELFTEST && st == $past(st, 4) |->
    o_wb_dat[15:0] == {3'h0, st[3:2], 6'h0, st[1:0], 3'h0})
    else $error("self test flags read wrong");
  a_caps_fixed_bits: assert property (
    o_config_caps_mirror[15:14] == 2'h1)
    else $error("fixed capability bits wrong");
  a_caps_mirror: assert property (
    rd && idx == MCR_IDX_CAPS && $stable(o_config_caps_mirror) |->
    o_wb_dat[15:0] == o_config_caps_mirror)
    else $error("capability mirror differs from register");
  a_caps_read_only: assert property (
    wr && idx == MCR_IDX_CAPS |=> $stable(o_config_caps_mirror) [*3])
    else $error("capabilities changed by a write");
  a_soft_bit_write: assert property (
    wr && idx == MCR_IDX_SOFT_RST |-> o_soft_reset == i_wb_dat[0])
    else $error("soft reset bit not written");
  a_soft_bit_holds: assert property (
    $fell(o_soft_reset) |-> wr && idx == MCR_IDX_SOFT_RST)
    else $error("soft reset cleared without a write");
  a_soft_defaults: assert property (
    o_soft_reset && $past(o_soft_reset, 2) |->
    o_bus_speed_sel == 2'h3 && pins == 3'h0)
    else $error("soft reset left registers changed");
endmodule
bind mcr_misc_ctrl mcr_misc_ctrl_chk #(.ADDR_W(ADDR_W)) chk_i (
  .i_mclk, .i_rst_n, .i_wb_we, .i_wb_adr, .i_wb_sel, .i_wb_dat,
  .o_wb_dat, .o_wb_ack, .i_eeprom_present_strap, .i_eeprom_serial_in,
  .o_eeprom_serial_out, .o_eeprom_serial_clock, .o_eeprom_select,
  .i_tx_selftest_done, .i_tx_selftest_fail, .i_rx_selftest_done,
  .i_rx_selftest_fail, .o_bus_speed_sel, .o_bus_clk_div, .o_soft_reset,
  .o_config_caps_mirror
);
`default_nettype wire

/* tb/test_misc_control_register_bank.sv */
// Testbench of the misc control register bank over classic Wishbone.
// Assumes the EEPROM model holds the word given as EE_WORD.
`default_nettype none
module test_misc_control_register_bank
  import mcr_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] EE_WORD = 16'hb3ff;
  localparam logic [15:0] CAPS = (EE_WORD & MCR_CAP_LOAD_MASK) | 16'h4000;
  localparam logic [11:0] A_SPD = 12'h840, A_EE = 12'h848, A_ST = 12'h850;
  localparam logic [11:0] A_SR = 12'h858, A_CAP = 12'h860, A_PM = 12'h880;
  localparam logic [15:0] DIVS [4] = '{16'h1, 16'h2, 16'h3, 16'h5};
  localparam logic [15:0] STM [4] = '{16'h1000, 16'h0800, 16'h10, 16'h8};
  logic clk = 1'h0, rst_n = 1'h0, strap = 1'h1, wake = 1'h0;
  logic cyc = 1'h0, stb = 1'h0, we = 1'h0;
  logic [11:0] adr = 12'h0;
  logic [31:0] wdat = 32'h0;
  logic [3:0] st = 4'h0;
  logic [31:0] rdat;
  logic ack, so, sk, cs, si, oe_n, wout, srst, go;
  logic [1:0] spd;
  logic [2:0] div;
  logic [15:0] mirror, q, e, word;
  int errors = 0, checks_done = 0, cyc_n = 0, starts = 0;
  // Clock of 10 ns period
  always #5 clk = ~clk;
  // Self test start, counted per cycle high
  always @(posedge clk) if (go === 1'h1) starts++;
  // Half period 4 covers pin register and synchroniser lag
  mcr_misc_ctrl #(.ADDR_W(12), .EE_HALF_CYC(4)) uut (
    .i_mclk(clk), .i_rst_n(rst_n), .i_ce(1'h1),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
    .i_wb_sel(4'h3), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_eeprom_present_strap(strap), .i_eeprom_serial_in(si),
    .o_eeprom_serial_out(so), .o_eeprom_serial_clock(sk),
    .o_eeprom_select(cs), .i_tx_selftest_done(st[3]),
    .i_tx_selftest_fail(st[2]), .i_rx_selftest_done(st[1]),
    .i_rx_selftest_fail(st[0]), .o_selftest_start(go),
    .i_wake_request(wake), .o_wake_event_out(wout),
    .o_wake_event_oe_n(oe_n), .o_bus_speed_sel(spd),
    .o_bus_clk_div(div), .o_soft_reset(srst),
    .o_config_caps_mirror(mirror)
  );
  mcr_eeprom_model #(.WORD(EE_WORD)) ee (
    .i_select(cs), .i_clock(sk), .i_data_in(so), .o_data_out(si)
  );
  // Hang guard
  always @(posedge clk) begin
    cyc_n++;
    if (cyc_n == 8000) begin
      errors++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] s, x);
    checks_done++;
    if (s !== x) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, x, s);
    end
  endtask
  // One classic cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [11:0] a, input logic [15:0] d);
    @(posedge clk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= {16'h0, d};
    @(posedge clk);
    while (ack !== 1'h1) @(posedge clk);
    q = rdat[15:0];
    cyc <= 1'h0;
    stb <= 1'h0;
  endtask
  task automatic rc(input string n, input logic [11:0] a,
    input logic [15:0] x);
    wb(1'h0, a, 16'h0);
    chk(n, q, x);
  endtask
  task automatic hw_reset(input logic s);
    rst_n <= 1'h0;
    strap <= s;
    repeat (20) @(posedge clk);
    rst_n <= 1'h1;
    repeat (300) @(posedge clk);
  endtask
  // One serial clock with select high and data b
  task automatic bang(input logic b);
    wb(1'h1, A_EE, {12'h001, 1'h0, b, 2'h1});
    wb(1'h1, A_EE, {12'h001, 1'h0, b, 2'h3});
  endtask
  task automatic wake_chk(input logic [15:0] c);
    wake <= 1'h1;
    @(posedge clk);
    wake <= 1'h0;
    for (int m = 0; m < 8; m++) begin
      wb(1'h1, A_PM, {7'h0, m[2], 6'h0, m[1:0]});
      repeat (3) @(posedge clk);
      chk("wake", {15'h0, oe_n}, {15'h0, !(m[2] && c[11 + m[1:0]])});
    end
    wb(1'h1, A_PM, 16'h8103);
    repeat (3) @(posedge clk);
    chk("wake cleared", {15'h0, oe_n}, 16'h1);
    chk("wake level", {15'h0, wout}, 16'h0);
  endtask
  initial begin
    hw_reset(1'h1);
    chk("start pulses", 16'(starts), 16'h1);
    rc("speed", A_SPD, 16'h3);
    chk("divide", {13'h0, div}, 16'h5);
    rc("soft bit", A_SR, 16'h0);
    rc("unmapped", 12'h870, 16'h0);
    rc("caps", A_CAP, CAPS);
    chk("mirror", mirror, CAPS);
    wb(1'h1, A_CAP, 16'h0);
    rc("caps kept", A_CAP, CAPS);
    $display("test reset values done");
    for (int s = 0; s < 4; s++) begin
      wb(1'h1, A_SPD, 16'(s));
      rc("speed", A_SPD, 16'(s));
      chk("divide", {13'h0, div}, DIVS[s]);
      chk("speed out", {14'h0, spd}, 16'(s));
    end
    $display("test speed codes done");
    for (int k = 15; k >= 0; k--) begin
      wb(1'h1, A_EE, {11'h0, k[3], 1'h1, k[2:0]});
      repeat (2) @(posedge clk);
      chk("pins", {13'h0, so, sk, cs}, k[3] ? 16'(k[2:0]) : 16'h0);
    end
    for (int i = 8; i >= 0; i--) bang(MCR_EE_READ_CMD[i]);
    for (int i = 15; i >= 0; i--) begin
      bang(1'h0);
      repeat (4) @(posedge clk);
      wb(1'h0, A_EE, 16'h0);
      word[i] = q[3];
    end
    chk("serial word", word, EE_WORD);
    wb(1'h1, A_EE, 16'h0);
    $display("test eeprom pins done");
    e = 16'h0;
    for (int i = 0; i < 4; i++) begin
      st <= 4'h8 >> i;
      @(posedge clk);
      st <= 4'h0;
      e = e | STM[i];
      repeat (3) @(posedge clk);
      rc("self test", A_ST, e);
    end
    wb(1'h1, A_ST, 16'h0);
    rc("self test", A_ST, 16'h1818);
    $display("test self test done");
    wb(1'h1, A_SPD, 16'h1);
    wb(1'h1, A_EE, 16'h17);
    wb(1'h1, A_SR, 16'h1);
    repeat (20) @(posedge clk);
    chk("soft out", {15'h0, srst}, 16'h1);
    rc("soft bit", A_SR, 16'h1);
    rc("speed", A_SPD, 16'h3);
    chk("pins", {13'h0, so, sk, cs}, 16'h0);
    wb(1'h1, A_SPD, 16'h0);
    rc("speed", A_SPD, 16'h3);
    rc("caps", A_CAP, CAPS);
    rc("self test", A_ST, 16'h1818);
    wb(1'h1, A_SR, 16'h0);
    repeat (2) @(posedge clk);
    chk("soft out", {15'h0, srst}, 16'h0);
    $display("test soft reset done");
    wake_chk(CAPS);
    $display("test wake done");
    hw_reset(1'h0);
    chk("start pulses", 16'(starts), 16'h2);
    rc("caps", A_CAP, 16'h4000);
    rc("self test", A_ST, 16'h0);
    wb(1'h1, A_EE, 16'h17);
    repeat (2) @(posedge clk);
    chk("pins", {13'h0, so, sk, cs}, 16'h0);
    wake_chk(16'h4000);
    $display("test no eeprom done");
    wrap_up();
  end
endmodule
`default_nettype wire
